/* design/frame_id_params.svh */
// Constants for the picture identification tagger
// Assumes inclusion by the package, the design module and the testbench
`ifndef FRAME_ID_PARAMS_SVH
`define FRAME_ID_PARAMS_SVH

// ==========================================
// Field widths and positions
`define FRAME_NUM_W      6
`define SRC_INFO_W       3
`define ID_W             9
`define ID_FRAME_LSB     0
`define ID_SRC_LSB       6
`define ID_BIT_CNT_W     4

// ==========================================
// Reset values and timing
`define FRAME_NUM_RST    6'h00
`define ID_RST           9'h000
`define SHIFT_DIV_W      8
`define SHIFT_DIV_DFLT   8'h0F

`endif

/* design/frame_id_pkg.sv */
// Types for the picture identification tagger
// Assumes frame_id_params.svh is on the include path
`include "frame_id_params.svh"

package frame_id_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } shift_state_t;

    typedef struct packed {
        logic       direct_mode;
        logic       camera_two;
        logic       spare;
    } src_info_t;

    typedef struct packed {
        src_info_t                 src;
        logic [`FRAME_NUM_W-1:0]   frame;
    } id_word_t;

    typedef struct packed {
        logic [2:0]                 vsync_sync;
        logic [`FRAME_NUM_W-1:0]    frame_cnt;
        logic                       load_pend;
        shift_state_t               state;
        id_word_t                   shreg;
        id_word_t                   lamps;
        logic [`ID_BIT_CNT_W-1:0]   bit_cnt;
        logic [`SHIFT_DIV_W-1:0]    div_cnt;
        logic                       tone_key;
    } tagger_state_t;

endpackage

/* design/frame_id_tagger.sv */
// Picture identification tagger: frame counter, id shift register, lamps and tone key
// Assumes vsync and command inputs are asynchronous levels from outside equipment
// Functional notes
// - Binary frame counter steps once per received picture vertical sync pulse.
// - Frame number is six bits wide.
// - Mode and camera source form a three-bit field beside the frame number.
// - Mode and camera inputs come from command equipment; direct/playback, camera 1/2.
// - Shift register holds all nine bits for the serial output; a separate lamp register holds the same word for the parallel outputs.
// - Each parallel output drives one indicator lamp beside the picture.
// - Serial output keys the tone oscillators for tape recording.
`timescale 1ns/1ns
`default_nettype none
`include "frame_id_params.svh"

module frame_id_tagger (
    input  wire logic                      clk_sys,
    input  wire logic                      rstn,
    input  wire logic                      vsync_in,
    input  wire logic                      direct_mode_in,
    input  wire logic                      camera_two_in,
    output logic [`ID_W-1:0]               lamp_out,
    output logic                           tone_key_out,
    output logic                           shift_busy
);
    import frame_id_pkg::*;

    tagger_state_t  s_q;
    tagger_state_t  s_d;
    logic [2:0]     cmd_m_q;
    logic [2:0]     cmd_s_q;

    // ==========================================
    // Command input synchronisers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cmd_m_q <= 3'h0;
            cmd_s_q <= 3'h0;
        end else begin
            cmd_m_q <= {direct_mode_in, camera_two_in, 1'b0};
            cmd_s_q <= cmd_m_q;
        end
    end

    wire vsync_rise = s_q.vsync_sync[1] & ~s_q.vsync_sync[2];

    // ==========================================
    // Identification word builder
    function automatic id_word_t build_id(
        input logic [`FRAME_NUM_W-1:0] frame,
        input logic [`SRC_INFO_W-1:0]  src
    );
        id_word_t w;
        w.frame = frame;
        w.src   = src_info_t'(src);
        return w;
    endfunction

    // ==========================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.vsync_sync = {s_q.vsync_sync[1:0], vsync_in};
        if (vsync_rise) begin
            s_d.frame_cnt = s_q.frame_cnt + `FRAME_NUM_W'(1);
            s_d.load_pend = 1'b1;
        end
        case (s_q.state)
            ST_IDLE: begin
                s_d.tone_key = 1'b0;
                if (s_q.load_pend) begin
                    s_d.load_pend  = vsync_rise;
                    s_d.shreg      = build_id(s_q.frame_cnt, cmd_s_q);
                    s_d.lamps      = build_id(s_q.frame_cnt, cmd_s_q);
                    s_d.bit_cnt    = `ID_BIT_CNT_W'(`ID_W);
                    s_d.div_cnt    = `SHIFT_DIV_DFLT;
                    s_d.state      = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (s_q.div_cnt == `SHIFT_DIV_W'(0)) begin
                    s_d.div_cnt = `SHIFT_DIV_DFLT;
                    if (s_q.bit_cnt == `ID_BIT_CNT_W'(0)) begin
                        s_d.tone_key = 1'b0;
                        s_d.state    = ST_IDLE;
                    end else begin
                        s_d.tone_key = s_q.shreg[`ID_W-1];
                        s_d.shreg    = id_word_t'({s_q.shreg[`ID_W-2:0], 1'b0});
                        s_d.bit_cnt  = s_q.bit_cnt - `ID_BIT_CNT_W'(1);
                    end
                end else begin
                    s_d.div_cnt = s_q.div_cnt - `SHIFT_DIV_W'(1);
                end
            end
            default: begin
                s_d.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q            <= '0;
            s_q.frame_cnt  <= `FRAME_NUM_RST;
            s_q.state      <= ST_IDLE;
            s_q.shreg      <= `ID_RST;
            s_q.lamps      <= `ID_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign lamp_out     = s_q.lamps;
    assign tone_key_out = s_q.tone_key;
    assign shift_busy   = (s_q.state == ST_SHIFT);

    // ==========================================
    // Assertions
    property p_count_step;
        @(posedge clk_sys) disable iff (!rstn)
        vsync_rise |=> s_q.frame_cnt == $past(s_q.frame_cnt) + `FRAME_NUM_W'(1);
    endproperty
    AST_FRAME_STEP: assert property (p_count_step) else $error("frame count did not step");

    AST_FRAME_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
        !vsync_rise |=> $stable(s_q.frame_cnt)) else $error("frame count moved without sync");

    AST_LOAD_START: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_q.state == ST_IDLE && s_q.load_pend) |=> shift_busy && lamp_out[`FRAME_NUM_W-1:0] == $past(s_q.frame_cnt))
        else $error("load did not start shift");

    AST_SRC_LOAD: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_q.state == ST_IDLE && s_q.load_pend) |=> lamp_out[`ID_W-1:`ID_SRC_LSB] == $past(cmd_s_q))
        else $error("source field not loaded");

    AST_MSB_FIRST: assert property (@(posedge clk_sys) disable iff (!rstn)
        (shift_busy && s_q.div_cnt == `SHIFT_DIV_W'(0) && s_q.bit_cnt != `ID_BIT_CNT_W'(0))
        |=> tone_key_out == $past(s_q.shreg[`ID_W-1])) else $error("serial bit wrong");

    AST_LAMP_STABLE: assert property (@(posedge clk_sys) disable iff (!rstn)
        shift_busy && $past(shift_busy) |-> $stable(lamp_out)) else $error("lamps changed during shift");

    AST_KEY_IDLE: assert property (@(posedge clk_sys) disable iff (!rstn)
        !shift_busy && $past(!shift_busy) |-> !tone_key_out) else $error("key active while idle");

    AST_SHIFT_END: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(shift_busy) |-> ##[150:170] !shift_busy) else $error("shift length wrong");

    COV_FRAME: cover property (@(posedge clk_sys) disable iff (!rstn) vsync_rise);
    COV_SHIFT: cover property (@(posedge clk_sys) disable iff (!rstn) $fell(shift_busy));
    COV_WRAP: cover property (@(posedge clk_sys) disable iff (!rstn)
        vsync_rise && s_q.frame_cnt == `FRAME_NUM_W'(63));

    // ==========================================
    // Views for the checks below
    logic                    shift_tick;
    logic                    last_bit;
    logic [`FRAME_NUM_W-1:0] lamp_frame;
    logic [`SRC_INFO_W-1:0]  lamp_src;

    assign shift_tick = (s_q.state == ST_SHIFT) && (s_q.div_cnt == `SHIFT_DIV_W'(0));
    assign last_bit   = (s_q.bit_cnt == `ID_BIT_CNT_W'(0));
    assign lamp_frame = lamp_out[`FRAME_NUM_W-1:0];
    assign lamp_src   = lamp_out[`ID_W-1:`ID_SRC_LSB];

    // ==========================================
    // State, counter range and sync pipe checks
    AST_STATE_ONEHOT: assert property (@(posedge clk_sys) disable iff (!rstn)
        $onehot(s_q.state)) else $error("state code not one-hot");

    AST_BIT_RANGE: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_q.bit_cnt <= `ID_BIT_CNT_W'(`ID_W)) else $error("bit count out of range");

    AST_DIV_RANGE: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_q.div_cnt <= `SHIFT_DIV_DFLT) else $error("divider out of range");

    AST_SYNC_PIPE: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_q.vsync_sync[2:1] == $past(s_q.vsync_sync[1:0])) else $error("sync pipe skipped a stage");

    // ==========================================
    // Serial key checks
    AST_KEY_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
        (shift_busy && !shift_tick) |=> $stable(tone_key_out)) else $error("key moved inside a bit");

    AST_KEY_FIRST_LOW: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(shift_busy) |-> !tone_key_out) else $error("key high before first bit");

    AST_LAST_TICK: assert property (@(posedge clk_sys) disable iff (!rstn)
        (shift_tick && last_bit) |=> (!shift_busy && !tone_key_out)) else $error("shift did not end");

    AST_DIV_RELOAD: assert property (@(posedge clk_sys) disable iff (!rstn)
        (shift_tick && !last_bit) |=> s_q.div_cnt == `SHIFT_DIV_DFLT) else $error("divider not reloaded");

    // ==========================================
    // Load and pending checks
    AST_PEND_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
        (vsync_rise && shift_busy) |=> s_q.load_pend) else $error("sync during shift was dropped");

    AST_PEND_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!shift_busy && s_q.load_pend && !vsync_rise) |=> !s_q.load_pend) else $error("pending load kept");

    AST_LOAD_MATCH: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(shift_busy) |-> s_q.shreg == s_q.lamps) else $error("shift word differs from lamps");

    AST_SPARE_LOW: assert property (@(posedge clk_sys) disable iff (!rstn)
        !lamp_src[0]) else $error("spare lamp lit");

    AST_FRAME_LAMP: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(shift_busy) |-> lamp_frame == s_q.frame_cnt || $past(vsync_rise))
        else $error("frame lamps wrong");

    COV_LATE_LOAD: cover property (@(posedge clk_sys) disable iff (!rstn) vsync_rise && shift_busy);
    COV_CAM_TWO: cover property (@(posedge clk_sys) disable iff (!rstn)
        $rose(shift_busy) && lamp_src[1] && !lamp_src[2]);
endmodule
`default_nettype wire

/* testbench/frame_source.sv */
// Model of the picture receiver sync and command equipment
// Assumes one system clock; all outputs move on its falling edge
`timescale 1ns/1ns
`default_nettype none
module frame_source (
    input  wire logic       clk_sys,
    input  wire logic       req,
    input  wire logic [1:0] sel,
    output logic            vsync_out,
    output logic            direct_out,
    output logic            camera_two_out
);
    logic [2:0] cnt_q = 3'h0;
    // ==========================================
    // Mode levels and one sync pulse per request
    always @(negedge clk_sys) begin
        direct_out     <= sel[1];
        camera_two_out <= sel[0];
        if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end else if (req) begin
            cnt_q <= 3'h6;
        end
    end
    assign vsync_out = (cnt_q > 3'h3);
endmodule
`default_nettype wire

/* testbench/tb_frame_id_tagger.sv */
// Testbench for the picture identification tagger
// Assumes the design package and header compile first
`timescale 1ns/1ns
`default_nettype none
`include "frame_id_params.svh"
module tb_frame_id_tagger;
    import frame_id_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rstn    = 1'b0;
    logic       req     = 1'b0;
    logic [1:0] sel     = 2'b00;
    logic [5:0] cnt_exp = 6'h00;
    wire logic  vsync, direct, cam;
    logic [8:0] lamps;
    logic       key, busy;
    int         mismatches = 0, n_compared = 0, cycles = 0;
    always #5 clk_sys = ~clk_sys;
    frame_source u_src (.clk_sys(clk_sys), .req(req), .sel(sel), .vsync_out(vsync),
                        .direct_out(direct), .camera_two_out(cam));
    frame_id_tagger u_dut (.clk_sys(clk_sys), .rstn(rstn), .vsync_in(vsync), .direct_mode_in(direct),
                           .camera_two_in(cam), .lamp_out(lamps), .tone_key_out(key), .shift_busy(busy));
    // ==========================================
    // Shared tasks
    task chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict;
        end
    end
    task wait_busy(input logic lvl);
        for (int i = 0; i < 300 && busy !== lvl; i++) @(negedge clk_sys);
        chk("busy", {8'h00, lvl}, {8'h00, busy});
    endtask
    task fire;
        req <= 1'b1;
        repeat (2) @(negedge clk_sys);
        req <= 1'b0;
        cnt_exp++;
    endtask
    // ==========================================
    // Scenarios
    task send_frame(input logic [1:0] s);
        logic [8:0] w;
        sel <= s;
        repeat (4) @(negedge clk_sys);
        fire;
        w = {s, 1'b0, cnt_exp};
        wait_busy(1'b1);
        chk("lamps", w, lamps);
        repeat (8) @(negedge clk_sys);
        for (int i = 8; i >= 0; i--) begin
            repeat (16) @(negedge clk_sys);
            chk("key bit", {8'h00, w[i]}, {8'h00, key});
        end
        wait_busy(1'b0);
        chk("key idle", 9'h000, {8'h00, key});
        $display("frame test done");
    endtask
    task sync_during_shift;
        sel <= 2'b11;
        fire;
        wait_busy(1'b1);
        chk("first load", {3'h6, cnt_exp}, lamps);
        repeat (30) @(negedge clk_sys);
        fire;
        wait_busy(1'b0);
        wait_busy(1'b1);
        chk("late load", {3'h6, cnt_exp}, lamps);
        wait_busy(1'b0);
        $display("sync during shift test done");
    endtask
    initial begin
        repeat (20) @(negedge clk_sys);
        chk("reset lamps", 9'h000, lamps);
        chk("reset key", 9'h000, {7'h00, key, busy});
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        for (int i = 0; i < 66; i++) send_frame(i[1:0]);
        sync_during_shift;
        give_verdict;
    end
endmodule
`default_nettype wire
